// File: flash_guard_pkg.sv
// Package for the flash program/erase guard: offsets, fields, reset values
package flash_guard_pkg;

	localparam logic [7:0] ctrl_one_offset   = 8'h00;
	localparam logic [7:0] ctrl_two_offset   = 8'h04;
	localparam logic [7:0] block_sel_offset  = 8'h08;
	localparam logic [7:0] status_offset     = 8'h0c;
	localparam logic [7:0] writer_cmd_offset = 8'h10;
	localparam logic [7:0] writer_sta_offset = 8'h14;

	// Control one field positions
	localparam int ctrl_one_prog_bit   = 0;
	localparam int ctrl_one_erase_bit  = 1;
	localparam int ctrl_one_pv_bit     = 2;
	localparam int ctrl_one_ev_bit     = 3;
	localparam int ctrl_one_swe_bit    = 6;
	// Control two field positions
	localparam int ctrl_two_psu_bit    = 0;
	localparam int ctrl_two_esu_bit    = 1;
	localparam int ctrl_two_err_bit    = 7;

	localparam logic [7:0] ctrl_one_reset  = 8'h00;
	localparam logic [7:0] ctrl_two_reset  = 8'h00;
	localparam logic [7:0] block_sel_reset = 8'h00;

	// Writer-mode command codes
	localparam logic [7:0] cmd_mem_read   = 8'h00;
	localparam logic [7:0] cmd_auto_prog  = 8'h40;
	localparam logic [7:0] cmd_auto_erase = 8'h20;
	localparam logic [7:0] cmd_status     = 8'h71;

	localparam int auto_op_cycles = 16;

	typedef enum logic [1:0] {
		resp_okay   = 2'b00,
		resp_slverr = 2'b10
	} axi_resp_t;

	typedef enum {
		wm_mem_read,
		wm_auto_prog,
		wm_auto_erase,
		wm_status
	} writer_mode_t;

	// CPU misbehaviour events watched during programming or erasing
	typedef struct packed {
		logic flash_read;
		logic exception_start;
		logic sleep_exec;
		logic bus_release;
	} cpu_events_t;

	// Strap pins sampled for external-programmer entry
	typedef struct packed {
		logic mode_select_high;
		logic mode_select_low;
		logic hw_standby_pin;
		logic p9_7;
		logic p9_2;
		logic p9_1;
		logic p9_0;
		logic p6_7;
	} straps_t;

endpackage

// File: flash_program_erase_guard.sv
// Flash program/erase protection guard with AXI4-Lite register slave
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Write-enable clear protects all blocks
// - Software protection refuses program and erase
// - Per-block select; zero protects every block
// - Resets and standby clear all control registers except the error flag
// - Hardware protection aborts active operation
// - Malfunction sets error flag, enters protection
// - Error keeps registers, aborts active mode
// - Error blocks re-entry to program/erase
// - Verify bits still accepted under error
// - Flash read during operation flags error
// - Non-reset exception during operation flags error
// - Sleep during operation flags error
// - Bus release during operation flags error
// - Only power-on reset clears error
// - Reads during request return undetermined data
// - Interrupts held off under error with request
// - Writer mode: read, auto program/erase, status
// - Status read shows internal status detail
module flash_program_erase_guard (
	input  wire logic                         clk_i,
	input  wire logic                         resetn_i,
	input  wire logic                         por_n_i,
	input  wire logic                         wdt_reset_i,
	input  wire logic                         standby_i,
	input  wire flash_guard_pkg::cpu_events_t events_i,
	input  wire flash_guard_pkg::straps_t     straps_i,
	input  wire logic [7:0]                   array_rdata_i,
	input  wire logic                         s_axi_awvalid,
	output logic                              s_axi_awready,
	input  wire logic [7:0]                   s_axi_awaddr,
	input  wire logic                         s_axi_wvalid,
	output logic                              s_axi_wready,
	input  wire logic [31:0]                  s_axi_wdata,
	input  wire logic [3:0]                   s_axi_wstrb,
	output logic                              s_axi_bvalid,
	input  wire logic                         s_axi_bready,
	output logic [1:0]                        s_axi_bresp,
	input  wire logic                         s_axi_arvalid,
	output logic                              s_axi_arready,
	input  wire logic [7:0]                   s_axi_araddr,
	output logic                              s_axi_rvalid,
	input  wire logic                         s_axi_rready,
	output logic [31:0]                       s_axi_rdata,
	output logic [1:0]                        s_axi_rresp,
	output logic                              program_active_o,
	output logic                              erase_active_o,
	output logic                              verify_active_o,
	output logic [7:0]                        block_enable_o,
	output logic                              irq_inhibit_o,
	output logic [7:0]                        read_data_o,
	output logic                              writer_mode_o
);

	logic [7:0]  ctrl_one_q;
	logic [7:0]  ctrl_two_q;
	logic [7:0]  block_sel_q;
	logic        err_q;
	logic        aw_held_q;
	logic        w_held_q;
	logic [7:0]  aw_addr_q;
	logic [31:0] w_data_q;
	logic        w_strb0_q;
	logic        wr_fire;
	logic        hw_protect;
	logic        request_set;
	logic        error_event;
	logic        wr_ok;
	logic        rd_ok;
	logic [31:0] rd_word;
	logic [7:0]  writer_cmd_q;
	logic [7:0]  writer_sta_q;
	logic        auto_busy_q;
	logic [4:0]  auto_cnt_q;
	logic        writer_straps;
	flash_guard_pkg::writer_mode_t wmode_q;

	// Write channel: address and data may arrive in either order
	assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

	// Address side
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			aw_held_q     <= 1'b0;
			aw_addr_q     <= 8'h00;
			s_axi_awready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (wr_fire) begin
				aw_held_q <= 1'b0;
			end
		end
	end

	// Data side
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			w_held_q     <= 1'b0;
			w_data_q     <= 32'h0000_0000;
			w_strb0_q    <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q  <= 1'b1;
				w_data_q  <= s_axi_wdata;
				w_strb0_q <= s_axi_wstrb[0];
			end
			if (wr_fire) begin
				w_held_q <= 1'b0;
			end
		end
	end

	// Response follows both halves; held until the master takes it
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'b00;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_ok ? flash_guard_pkg::resp_okay : flash_guard_pkg::resp_slverr;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_comb begin
		case (aw_addr_q)
			flash_guard_pkg::ctrl_one_offset,
			flash_guard_pkg::ctrl_two_offset,
			flash_guard_pkg::block_sel_offset,
			flash_guard_pkg::status_offset,
			flash_guard_pkg::writer_cmd_offset,
			flash_guard_pkg::writer_sta_offset: wr_ok = 1'b1;
			default:                            wr_ok = 1'b0;
		endcase
	end

	assign hw_protect  = wdt_reset_i || standby_i;
	assign request_set = ctrl_one_q[flash_guard_pkg::ctrl_one_prog_bit]
		|| ctrl_one_q[flash_guard_pkg::ctrl_one_erase_bit];
	// Only watched while an operation is requested
	assign error_event = request_set && (events_i.flash_read
		|| events_i.exception_start
		|| events_i.sleep_exec
		|| events_i.bus_release);

	// Control registers; retained under error, changed only by writes, reset, watchdog reset or standby
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctrl_one_q <= flash_guard_pkg::ctrl_one_reset;
		end else if (hw_protect) begin
			ctrl_one_q <= flash_guard_pkg::ctrl_one_reset;
		end else if (wr_fire && w_strb0_q && aw_addr_q == flash_guard_pkg::ctrl_one_offset) begin
			ctrl_one_q <= w_data_q[7:0];
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctrl_two_q <= flash_guard_pkg::ctrl_two_reset;
		end else if (hw_protect) begin
			ctrl_two_q <= flash_guard_pkg::ctrl_two_reset;
		end else if (wr_fire && w_strb0_q && aw_addr_q == flash_guard_pkg::ctrl_two_offset) begin
			ctrl_two_q <= w_data_q[7:0];
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			block_sel_q <= flash_guard_pkg::block_sel_reset;
		end else if (hw_protect) begin
			block_sel_q <= flash_guard_pkg::block_sel_reset;
		end else if (wr_fire && w_strb0_q && aw_addr_q == flash_guard_pkg::block_sel_offset) begin
			block_sel_q <= w_data_q[7:0];
		end
	end

	// Error flag: cleared only by power-on reset, never by write or other reset
	always_ff @(posedge clk_i or negedge por_n_i) begin
		if (!por_n_i) begin
			err_q <= 1'b0;
		end else if (error_event) begin
			err_q <= 1'b1;
		end
	end

	// Program and erase entry: write-enable, no error, no hardware protect
	op_qualify program_gate_u (
		.clk_i          (clk_i),
		.resetn_i       (resetn_i),
		.write_enable_i (ctrl_one_q[flash_guard_pkg::ctrl_one_swe_bit]),
		.blocked_i      (err_q || error_event || hw_protect),
		.request_i      (ctrl_one_q[flash_guard_pkg::ctrl_one_prog_bit]),
		.setup_i        (ctrl_two_q[flash_guard_pkg::ctrl_two_psu_bit]),
		.block_sel_i    (block_sel_q),
		.active_o       (program_active_o)
	);

	op_qualify erase_gate_u (
		.clk_i          (clk_i),
		.resetn_i       (resetn_i),
		.write_enable_i (ctrl_one_q[flash_guard_pkg::ctrl_one_swe_bit]),
		.blocked_i      (err_q || error_event || hw_protect),
		.request_i      (ctrl_one_q[flash_guard_pkg::ctrl_one_erase_bit]),
		.setup_i        (ctrl_two_q[flash_guard_pkg::ctrl_two_esu_bit]),
		.block_sel_i    (block_sel_q),
		.active_o       (erase_active_o)
	);

	// Verify and block enables, registered straight to outputs
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			verify_active_o <= 1'b0;
			block_enable_o  <= 8'h00;
		end else begin
			// Verify stays available under error
			verify_active_o <= ctrl_one_q[flash_guard_pkg::ctrl_one_swe_bit] && !hw_protect
				&& (ctrl_one_q[flash_guard_pkg::ctrl_one_pv_bit] || ctrl_one_q[flash_guard_pkg::ctrl_one_ev_bit]);
			block_enable_o  <= ctrl_one_q[flash_guard_pkg::ctrl_one_swe_bit] ? block_sel_q : 8'h00;
		end
	end

	// What the CPU side sees while a request bit stands
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			irq_inhibit_o <= 1'b0;
			read_data_o   <= 8'h00;
		end else begin
			// Held off while a request is set, error or not
			irq_inhibit_o <= request_set;
			// Undetermined while requested; all ones so nothing stale leaks out
			read_data_o   <= request_set ? 8'hff : array_rdata_i;
		end
	end

	// Writer mode entry from board straps, sampled every clock while out of reset
	assign writer_straps = !straps_i.mode_select_high && !straps_i.mode_select_low
		&& straps_i.hw_standby_pin && !straps_i.p9_2 && !straps_i.p6_7
		&& straps_i.p9_7 && straps_i.p9_1 && straps_i.p9_0;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			writer_mode_o <= 1'b0;
		end else begin
			writer_mode_o <= writer_straps;
		end
	end

	// Writer command decode and the auto operation timer
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wmode_q       <= flash_guard_pkg::wm_mem_read;
			writer_cmd_q  <= 8'h00;
			writer_sta_q  <= 8'h00;
			auto_busy_q   <= 1'b0;
			auto_cnt_q    <= 5'd0;
		end else begin
			// Commands during an auto operation are dropped, not queued
			if (auto_busy_q) begin
				if (auto_cnt_q == 5'(flash_guard_pkg::auto_op_cycles - 1)) begin
					auto_busy_q     <= 1'b0;
					writer_sta_q[7] <= 1'b1; // Completion seen by status polling
				end
				auto_cnt_q <= auto_cnt_q + 5'd1;
			end else if (writer_mode_o && wr_fire && w_strb0_q
					&& aw_addr_q == flash_guard_pkg::writer_cmd_offset) begin
				writer_cmd_q <= w_data_q[7:0];
				case (w_data_q[7:0])
					flash_guard_pkg::cmd_mem_read: wmode_q <= flash_guard_pkg::wm_mem_read;
					flash_guard_pkg::cmd_auto_prog: begin
						wmode_q      <= flash_guard_pkg::wm_auto_prog;
						auto_busy_q  <= 1'b1;
						auto_cnt_q   <= 5'd0;
						writer_sta_q <= 8'h01;
					end
					flash_guard_pkg::cmd_auto_erase: begin
						wmode_q      <= flash_guard_pkg::wm_auto_erase;
						auto_busy_q  <= 1'b1;
						auto_cnt_q   <= 5'd0;
						writer_sta_q <= 8'h02;
					end
					flash_guard_pkg::cmd_status: wmode_q <= flash_guard_pkg::wm_status;
					default: writer_sta_q[6] <= 1'b1; // Unknown command flagged
				endcase
			end
		end
	end

	// Read channel, one cycle after address accepted
	always_comb begin
		rd_ok   = 1'b1;
		rd_word = 32'h0000_0000;
		case (s_axi_araddr)
			flash_guard_pkg::ctrl_one_offset:  rd_word[7:0] = ctrl_one_q;
			flash_guard_pkg::ctrl_two_offset:  rd_word[7:0] = {err_q, ctrl_two_q[6:0]};
			flash_guard_pkg::block_sel_offset: rd_word[7:0] = block_sel_q;
			flash_guard_pkg::status_offset:
				rd_word[5:0] = {writer_mode_o, irq_inhibit_o, verify_active_o,
					erase_active_o, program_active_o, err_q};
			flash_guard_pkg::writer_cmd_offset: rd_word[7:0] = writer_cmd_q;
			// Internal status detail only in status read mode
			flash_guard_pkg::writer_sta_offset:
				rd_word[8:0] = (wmode_q == flash_guard_pkg::wm_status)
					? {auto_busy_q, writer_sta_q} : 9'h000;
			default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'b00;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word;
				s_axi_rresp  <= rd_ok ? flash_guard_pkg::resp_okay : flash_guard_pkg::resp_slverr;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule

// Registered gate shared by program and erase entry
module op_qualify #(
	parameter int block_count = 8
) (
	input  wire logic                   clk_i,
	input  wire logic                   resetn_i,
	input  wire logic                   write_enable_i,
	input  wire logic                   blocked_i,
	input  wire logic                   request_i,
	input  wire logic                   setup_i,
	input  wire logic [block_count-1:0] block_sel_i,
	output logic                        active_o
);

	// Any single blocker keeps the array out of program or erase
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			active_o <= 1'b0;
		end else begin
			active_o <= write_enable_i && !blocked_i && request_i && setup_i
				&& (block_sel_i != '0);
		end
	end

endmodule

`default_nettype wire

// File: flash_guard_chk.sv
// Protection assertions for the flash program/erase guard
`timescale 1ns/1ps
`default_nettype none
module flash_guard_chk (
	input wire logic                         clk_i,
	input wire logic                         resetn_i,
	input wire logic                         por_n_i,
	input wire logic                         wdt_reset_i,
	input wire logic                         standby_i,
	input wire flash_guard_pkg::cpu_events_t events_i,
	input wire flash_guard_pkg::straps_t     straps_i,
	input wire logic                         s_axi_bvalid,
	input wire logic                         s_axi_bready,
	input wire logic                         s_axi_rvalid,
	input wire logic                         s_axi_rready,
	input wire logic [31:0]                  s_axi_rdata,
	input wire logic                         program_active_o,
	input wire logic                         erase_active_o,
	input wire logic [7:0]                   block_enable_o,
	input wire logic                         irq_inhibit_o,
	input wire logic [7:0]                   read_data_o,
	input wire logic                         writer_mode_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	logic err_q;
	logic act;
	assign act = program_active_o || erase_active_o;
	// Shadow of the error flag; system reset must not clear it
	always_ff @(posedge clk_i or negedge por_n_i)
		if (!por_n_i) err_q <= 1'b0;
		else if (irq_inhibit_o && $past(irq_inhibit_o) && |events_i) err_q <= 1'b1;
	property p_sel;
		act |-> block_enable_o != 8'h00 || $past(block_enable_o) != 8'h00;
	endproperty
	a_sel: assert property (p_sel) else $error("active with no block enabled");
	property p_req;
		act |-> irq_inhibit_o || $past(irq_inhibit_o);
	endproperty
	a_req: assert property (p_req) else $error("active without request");
	property p_abort;
		irq_inhibit_o && $past(irq_inhibit_o) && |events_i |-> ##2 !act;
	endproperty
	a_abort: assert property (p_abort) else $error("event did not abort");
	property p_err;
		err_q && $past(err_q) |-> !act;
	endproperty
	a_err: assert property (p_err) else $error("operation under error");
	property p_undet;
		irq_inhibit_o && $past(irq_inhibit_o) |-> read_data_o == 8'hff;
	endproperty
	a_undet: assert property (p_undet) else $error("array data during request");
	property p_hw;
		wdt_reset_i || standby_i |-> ##3 !act && block_enable_o == 8'h00;
	endproperty
	a_hw: assert property (p_hw) else $error("hardware protect missed");
	property p_strap;
		($stable(straps_i) && $past(resetn_i))[*3] |-> writer_mode_o == (straps_i == 8'h36);
	endproperty
	a_strap: assert property (p_strap) else $error("writer mode mismatch");
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read answer dropped");
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_bhold: assert property (p_bhold) else $error("write answer dropped");
	cover property (err_q);
	cover property (erase_active_o);
	cover property (writer_mode_o);
endmodule
bind flash_program_erase_guard flash_guard_chk chk_u (.*);
`default_nettype wire

// File: flash_array_model.sv
// Flash array stand-in feeding read data to the guard
`timescale 1ns/1ps
`default_nettype none
module flash_array_model (
	input  wire logic       clk_i,
	input  wire logic       resetn_i,
	output logic      [7:0] rdata_o
);
	// Changes every cycle so stale data is never mistaken for valid
	always_ff @(posedge clk_i or negedge resetn_i)
		if (!resetn_i) rdata_o <= 8'h5a;
		else rdata_o <= {rdata_o[6:0], ~rdata_o[7]};
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking bench for the flash program/erase guard
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk_i = 0, resetn_i = 0, por_n_i = 0, wdt_reset_i = 0, standby_i = 0;
	flash_guard_pkg::cpu_events_t events_i = '0;
	flash_guard_pkg::straps_t straps_i = '0;
	logic [7:0] array_rdata_i, s_axi_awaddr = '0, s_axi_araddr = '0, block_enable_o, read_data_o;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, seed = 32'h2956f179;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic program_active_o, erase_active_o, verify_active_o, irq_inhibit_o, writer_mode_o;
	int miscompares = 0, comparisons = 0;
	flash_program_erase_guard dut_u (.*);
	flash_array_model arr_u (.clk_i(clk_i), .resetn_i(resetn_i), .rdata_o(array_rdata_i));
	initial forever #25 clk_i = ~clk_i;
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// Control two after a latched error: flag plus retained setup bit
	function automatic logic [31:0] err_ctl(input int m);
		return 32'h80 | (32'h1 << m);
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic end_sim;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		s_axi_awvalid <= 1;
		s_axi_awaddr <= a;
		s_axi_wvalid <= 1;
		s_axi_wdata <= d;
		for (n = 0; n < 50; n++) begin
			@(posedge clk_i);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid && s_axi_bready) break;
			s_axi_bready <= (n > 0);
		end
		s_axi_bready <= 0;
		if (n == 50) begin
			miscompares++;
			end_sim();
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge clk_i);
		s_axi_arvalid <= 1;
		s_axi_araddr <= a;
		for (n = 0; n < 50; n++) begin
			@(posedge clk_i);
			if (s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid && s_axi_rready) break;
			s_axi_rready <= (n > 0);
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 0;
		if (n == 50) begin
			miscompares++;
			end_sim();
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk($sformatf("reg %h", a), e, d);
	endtask
	// One-cycle pulse on standby, watchdog and the event inputs
	task automatic hit(input logic [5:0] v);
		@(posedge clk_i);
		{standby_i, wdt_reset_i, events_i} <= v;
		@(posedge clk_i);
		{standby_i, wdt_reset_i, events_i} <= '0;
		repeat (3) @(posedge clk_i);
	endtask
	task automatic rst(input logic p);
		@(posedge clk_i);
		resetn_i <= 0;
		por_n_i <= !p;
		repeat (10) @(posedge clk_i);
		resetn_i <= 1;
		por_n_i <= 1;
		repeat (2) @(posedge clk_i);
	endtask
	task automatic arm(input int m, input logic [7:0] bs, input logic w);
		wr(8'h08, {24'h0, bs});
		wr(8'h04, 32'h1 << m);
		wr(8'h00, {25'h0, w, 6'h0} | (32'h1 << m));
		repeat (3) @(posedge clk_i);
	endtask
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		rst(1);
		rc(8'h00, 0);
		rc(8'h08, 0);
		rd(8'h20, d, r);
		chk("unmapped resp", 32'h2, {30'h0, r});
		wr(8'h20, 32'h1);
		chk("unmapped wresp", 32'h2, {30'h0, s_axi_bresp});
		straps_i <= 8'h36;
		repeat (5) @(posedge clk_i);
		chk("writer mode", 1, {31'h0, writer_mode_o});
		straps_i <= 8'h36 ^ (8'h1 << seed[2:0]);
		repeat (5) @(posedge clk_i);
		chk("writer mode", 0, {31'h0, writer_mode_o});
		$display("test reset and straps done");
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			arm(i % 2, {seed[7:1], 1'b1}, 0);
			chk("active", 0, {30'h0, erase_active_o, program_active_o});
			chk("block enable", 0, {24'h0, block_enable_o});
			chk("undet read", 32'hff, {24'h0, read_data_o});
			arm(i % 2, 8'h00, 1);
			chk("active", 0, {30'h0, erase_active_o, program_active_o});
			arm(i % 2, {seed[7:1], 1'b1}, 1);
			chk("active", 32'h1 << (i % 2), {30'h0, erase_active_o, program_active_o});
			chk("block enable", {24'h0, seed[7:1], 1'b1}, {24'h0, block_enable_o});
			hit(6'h10 << (i / 2));
			chk("active", 0, {30'h0, erase_active_o, program_active_o});
			rc(8'h00, 0);
			rc(8'h04, 0);
			rc(8'h08, 0);
		end
		$display("test protection done");
		for (int e = 0; e < 4; e++) begin
			seed = lfsr(seed);
			hit({2'b00, seed[3:0] | 4'h1});
			rc(8'h04, 0);
			arm(e % 2, 8'h01, 1); // Events stay quiet while armed
			hit({2'b00, 4'h1 << e});
			chk("active", 0, {30'h0, erase_active_o, program_active_o});
			rc(8'h04, err_ctl(e % 2));
			rc(8'h08, 32'h1);
			chk("irq inhibit", 1, {31'h0, irq_inhibit_o});
			wr(8'h00, 32'h40 | (32'h1 << (e % 2)));
			repeat (3) @(posedge clk_i);
			chk("active", 0, {30'h0, erase_active_o, program_active_o});
			wr(8'h00, 32'h40 | (32'h4 << (e % 2)));
			repeat (3) @(posedge clk_i);
			chk("verify", 1, {31'h0, verify_active_o});
			rst(0);
			rc(8'h04, 32'h80);
			rst(1);
			rc(8'h04, 0);
		end
		$display("test error protection done");
		straps_i <= 8'h36;
		repeat (3) @(posedge clk_i);
		rc(flash_guard_pkg::status_offset, 32'h20);
		for (int c = 0; c < 2; c++) begin
			wr(flash_guard_pkg::writer_cmd_offset,
				{24'h0, c ? flash_guard_pkg::cmd_auto_erase : flash_guard_pkg::cmd_auto_prog});
			repeat (flash_guard_pkg::auto_op_cycles + 4) @(posedge clk_i);
			wr(flash_guard_pkg::writer_cmd_offset, {24'h0, flash_guard_pkg::cmd_status});
			rc(flash_guard_pkg::writer_sta_offset, 32'h80 | (32'h1 << c));
		end
		wr(flash_guard_pkg::writer_cmd_offset, {24'h0, flash_guard_pkg::cmd_mem_read});
		rc(flash_guard_pkg::writer_sta_offset, 0);
		rc(flash_guard_pkg::writer_cmd_offset, {24'h0, flash_guard_pkg::cmd_mem_read});
		d = {24'h0, array_rdata_i};
		@(posedge clk_i);
		chk("array read", d, {24'h0, read_data_o});
		$display("test writer mode done");
		end_sim();
	end
endmodule
`default_nettype wire
